// ### verilog/tcc_timer.v
// Timer counter control core with AHB-Lite register slave
`timescale 1ns/1ps
`include "tcc_consts.vh"

// Functional notes
// (RQ1) Clock select 000-110 picks bus clock /1../64, 111 the pin; reset 000.
// (RQ2) External clock must stay at or below 4 MHz and half bus clock.
// (RQ3) Shared pin is forced to input while selected as timer clock.
// (RQ4) Counter equal to limit sets overflow flag and restarts from zero.
// (RQ5) Overflow flag clears by read-while-set then write 0; new overflow wins.
// (RQ6) Overflow request raised while flag and its enable are both set.
// (RQ7) Halt bit holds the counter; reset sets it.
// (RQ8) Counter reset bit clears prescaler and counter, self-clears, reads 0.
// (RQ9) Halt plus counter reset in one write leaves counter halted at 0.
// (RQ10) High byte read latches low byte until low byte is read.
// (RQ11) Count bytes are read-only, zero after reset and counter reset.
// (RQ12) Limit high write blocks overflow flag until limit low write.
// (RQ13) Limit registers reset to all ones.
// (RQ14) Software resets the counter before writing new limit values.
// (RQ15) Channel flag set by active edge in capture, by match in compare.
// (RQ16) Channel flag clears by read-while-set then write 0; new event wins.
// (RQ17) Channel request raised while flag and channel enable are set.
// (RQ18) Reset clears all six channel status and control registers.
// (RQ19) Channel bit order flag..full duty; odd channels read buffered bit 0.
// (RQ20) Each channel capture or compare; only even channels buffered.
// (RQ21) Mode and edge bits select capture edge or compare pin action.
// (RQ22) Overflow toggle bit toggles pin on overflow, beating a compare.
// (RQ23) Unhalted counter steps once per selected, synchronised tick.
module tcc_timer (
	// Clock and reset
	input  wire        sys_clk_i,
	input  wire        arst_n_i,
	// AHB-Lite slave
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output reg  [31:0] hrdata_o,
	output reg         hreadyout_o,
	output reg         hresp_o,
	// Shared external clock pin
	input  wire        shared_clock_pin_i,
	input  wire        pin_direction_bit_i,
	output reg         shared_clock_pin_oe_n_o,
	// Channel pins
	input  wire [5:0]  channel_pin_i,
	output wire [5:0]  channel_pin_o,
	output wire [5:0]  channel_pin_oe_n_o,
	// Interrupt requests
	output reg         overflow_irq_o,
	output wire [5:0]  channel_irq_o
);

	localparam [47:0] CH_IDX = `TCC_CH_SC_IDX;

	// ****************************************************************
	// Bus slave
	// ****************************************************************

	reg        wr_q;
	reg [7:0]  idx_q;
	reg [7:0]  rbyte;
	reg [7:0]  ci;
	integer    j;

	wire       acc   = hsel_i & hready_i & htrans_i[1];
	wire       rd    = acc & ~hwrite_i;
	wire [7:0] idx   = haddr_i[9:2];
	wire [7:0] wb    = hwdata_i[7:0];

	// Address phase captured; writes land at end of data phase
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_q        <= 1'b0;
			idx_q       <= 8'h00;
			hrdata_o    <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			wr_q        <= acc & hwrite_i;
			idx_q       <= idx;
			hreadyout_o <= 1'b1; // Never stretches a transfer
			hresp_o     <= 1'b0;
			if (rd)
				hrdata_o <= {24'h00_0000, rbyte};
		end
	end

	// Write strobes, data phase
	wire wr_main   = wr_q & (idx_q == `TCC_IDX_MAIN);
	wire wr_mod_hi = wr_q & (idx_q == `TCC_IDX_MOD_HI);
	wire wr_mod_lo = wr_q & (idx_q == `TCC_IDX_MOD_LO);
	// Read strobes, address phase, for read side effects
	wire rd_main   = rd & (idx == `TCC_IDX_MAIN);
	wire rd_cnt_hi = rd & (idx == `TCC_IDX_CNT_HI);
	wire rd_cnt_lo = rd & (idx == `TCC_IDX_CNT_LO);

	// ****************************************************************
	// Main control state
	// ****************************************************************

	reg        flag;
	reg        armed;
	reg        irq_en;
	reg        stop;
	reg [2:0]  ps;
	reg [15:0] cnt;
	reg [5:0]  pre;
	reg [15:0] modv;
	reg        mod_inh;
	reg [7:0]  lat_buf;
	reg        latched;
	reg        step_q;
	reg        wrap_q;
	reg        e1;
	reg        e2;
	reg        e3;

	wire       trst_w  = wr_main & wb[`TCC_MAIN_RST]; // RQ8
	wire [5:0] pmask   = ~(6'h3F << ps);
	wire       ext_sel = (ps == `TCC_PS_EXT);
	wire       ext_tick = e2 & ~e3;
	wire       tick    = ext_sel ? ext_tick : (&(pre | ~pmask)); // RQ1
	wire       run     = ~stop & tick & ~trst_w; // RQ7
	wire       at_mod  = (cnt == modv);
	wire       wrap    = run & at_mod;
	wire       ovf_set = wrap & ~mod_inh; // RQ12

	// External clock synchroniser; e1 feeds only e2
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			e1 <= 1'b0;
			e2 <= 1'b0;
			e3 <= 1'b0;
		end else begin
			e1 <= shared_clock_pin_i; // RQ23
			e2 <= e1;
			e3 <= e2;
		end
	end

	// Shared pin forced to input while it clocks the timer
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			shared_clock_pin_oe_n_o <= 1'b1;
		else
			shared_clock_pin_oe_n_o <= ext_sel | ~pin_direction_bit_i; // RQ3
	end

	// Control fields; the counter reset bit is never stored
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_en <= 1'b0; // RQ6
			stop   <= 1'b1; // RQ7
			ps     <= `TCC_PS_RST; // RQ1
		end else if (wr_main) begin
			irq_en <= wb[`TCC_MAIN_IE];
			stop   <= wb[`TCC_MAIN_STOP]; // RQ9
			ps     <= wb[2:0]; // RQ1
		end
	end

	// Prescaler runs only while the counter runs
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			pre <= 6'h00;
		else if (trst_w)
			pre <= 6'h00; // RQ8
		else if (!stop)
			pre <= pre + 6'h01;
	end

	// Counter with modulo wrap; counter reset wins over a tick
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt    <= 16'h0000; // RQ11
			step_q <= 1'b0;
			wrap_q <= 1'b0;
		end else begin
			step_q <= run;
			wrap_q <= wrap;
			if (trst_w)
				cnt <= 16'h0000; // RQ9
			else if (run)
				cnt <= at_mod ? 16'h0000 : cnt + 16'h0001; // RQ4
		end
	end

	// Overflow flag with two-step clear; a new overflow wins
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag  <= 1'b0; // RQ5
			armed <= 1'b0;
		end else begin
			if (ovf_set)
				flag <= 1'b1; // RQ4
			else if (wr_main & ~wb[`TCC_MAIN_FLAG] & armed)
				flag <= 1'b0; // RQ5
			if (ovf_set)
				armed <= 1'b0; // RQ5
			else if (rd_main & flag)
				armed <= 1'b1; // RQ5
			else if (wr_main)
				armed <= 1'b0;
		end
	end

	// Overflow request follows flag and enable
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			overflow_irq_o <= 1'b0;
		else
			overflow_irq_o <= flag & irq_en; // RQ6
	end

	// Wrap limit; high write holds off the flag until low write
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			modv    <= `TCC_MOD_RST; // RQ13
			mod_inh <= 1'b0;
		end else if (wr_mod_hi) begin
			modv[15:8] <= wb;
			mod_inh    <= 1'b1; // RQ12
		end else if (wr_mod_lo) begin
			modv[7:0] <= wb;
			mod_inh   <= 1'b0; // RQ12
		end
	end

	// Coherent count read; repeated high reads keep the first latch
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lat_buf <= 8'h00;
			latched <= 1'b0;
		end else if (trst_w) begin
			lat_buf <= 8'h00; // RQ11
			latched <= 1'b0;
		end else if (rd_cnt_hi & ~latched) begin
			lat_buf <= cnt[7:0]; // RQ10
			latched <= 1'b1;
		end else if (rd_cnt_lo) begin
			latched <= 1'b0; // RQ10
		end
	end

	// ****************************************************************
	// Channels
	// ****************************************************************

	wire [47:0] ch_sc;
	wire [95:0] ch_val;
	// Odd channel goes idle while its even partner is buffered
	wire [5:0]  ch_link = {ch_sc[37], 1'b0, ch_sc[21], 1'b0, ch_sc[5], 1'b0};

	genvar i;
	generate
		for (i = 0; i < 6; i = i + 1) begin : g_ch
			localparam [7:0] SCI = CH_IDX[i*8 +: 8];
			tcc_channel #(
				.HAS_BUF ((i % 2 == 0) ? 1 : 0) // RQ20
			) u_ch (
				.sys_clk_i  (sys_clk_i),
				.arst_n_i   (arst_n_i),
				.sc_wr_i    (wr_q & (idx_q == SCI)),
				.sc_rd_i    (rd & (idx == SCI)),
				.hi_wr_i    (wr_q & (idx_q == SCI + `TCC_VAL_HI_OFS)),
				.lo_wr_i    (wr_q & (idx_q == SCI + `TCC_VAL_LO_OFS)),
				.wdata_i    (wb),
				.count_i    (cnt),
				.step_i     (step_q),
				.wrap_i     (wrap_q),
				.link_off_i (ch_link[i]),
				.pin_i      (channel_pin_i[i]),
				.pin_o      (channel_pin_o[i]),
				.pin_oe_n_o (channel_pin_oe_n_o[i]),
				.sc_o       (ch_sc[i*8 +: 8]),
				.value_o    (ch_val[i*16 +: 16]),
				.irq_o      (channel_irq_o[i])
			);
		end
	endgenerate

	// ****************************************************************
	// Read multiplexer
	// ****************************************************************

	// Unmapped indices read zero and still answer OKAY
	always @* begin
		ci = 8'h00;
		case (idx)
		`TCC_IDX_MAIN:
			rbyte = {flag, irq_en, stop, 2'b00, ps}; // RQ8
		`TCC_IDX_CNT_HI:
			rbyte = cnt[15:8]; // RQ11
		`TCC_IDX_CNT_LO:
			rbyte = latched ? lat_buf : cnt[7:0]; // RQ10
		`TCC_IDX_MOD_HI:
			rbyte = modv[15:8];
		`TCC_IDX_MOD_LO:
			rbyte = modv[7:0];
		default:
			rbyte = 8'h00;
		endcase
		for (j = 0; j < 6; j = j + 1) begin
			ci = CH_IDX[j*8 +: 8];
			if (idx == ci)
				rbyte = ch_sc[j*8 +: 8]; // RQ19
			else if (idx == ci + `TCC_VAL_HI_OFS)
				rbyte = ch_val[j*16+8 +: 8];
			else if (idx == ci + `TCC_VAL_LO_OFS)
				rbyte = ch_val[j*16 +: 8];
		end
	end

endmodule

// ### verilog/tcc_consts.vh
// Register indices, field positions, reset values for the timer core
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define TCC_IDX_MAIN    8'h20
`define TCC_IDX_CNT_HI  8'h21
`define TCC_IDX_CNT_LO  8'h22
`define TCC_IDX_MOD_HI  8'h23
`define TCC_IDX_MOD_LO  8'h24
// Channel status/control indices, channel 5 down to channel 0
`define TCC_CH_SC_IDX   {8'h35, 8'h32, 8'h2F, 8'h2C, 8'h29, 8'h26}
`define TCC_VAL_HI_OFS  8'h01
`define TCC_VAL_LO_OFS  8'h02

// ****************************************************************
// Main status and control fields
// ****************************************************************
`define TCC_MAIN_FLAG   7
`define TCC_MAIN_IE     6
`define TCC_MAIN_STOP   5
`define TCC_MAIN_RST    4
`define TCC_PS_EXT      3'h7
`define TCC_PS_RST      3'h0
`define TCC_MOD_RST     16'hFFFF

// ****************************************************************
// Channel status and control fields
// ****************************************************************
`define TCC_CH_FLAG     7
`define TCC_CH_IE       6
`define TCC_CH_MSB      5
`define TCC_CH_MSA      4
`define TCC_CH_ELSB     3
`define TCC_CH_ELSA     2
`define TCC_CH_TOV      1
`define TCC_CH_MAX      0
`define TCC_CH_RST      7'h00
`define TCC_EDGE_TOG    2'h1
`define TCC_EDGE_CLR    2'h2
`define TCC_EDGE_SET    2'h3

`endif

// ### verilog/tcc_channel.v
// One capture/compare channel: flag, enables, mode, value, pin action
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_channel #(
	parameter HAS_BUF = 1
) (
	// Clock and reset
	input  wire        sys_clk_i,
	input  wire        arst_n_i,
	// Register strobes from the bus slave
	input  wire        sc_wr_i,
	input  wire        sc_rd_i,
	input  wire        hi_wr_i,
	input  wire        lo_wr_i,
	input  wire [7:0]  wdata_i,
	// Counter state
	input  wire [15:0] count_i,
	input  wire        step_i,
	input  wire        wrap_i,
	input  wire        link_off_i,
	// Channel pin
	input  wire        pin_i,
	output reg         pin_o,
	output reg         pin_oe_n_o,
	// Register view and request
	output wire [7:0]  sc_o,
	output wire [15:0] value_o,
	output reg         irq_o
);

	reg        flag;
	reg        armed;
	reg        inh;
	reg [6:0]  ctl;
	reg [15:0] val;
	reg        s1;
	reg        s2;
	reg        s3;

	// Decoded mode; odd channels have no buffered bit
	wire       msb      = (HAS_BUF != 0) ? ctl[`TCC_CH_MSB] : 1'b0;
	wire       msa      = ctl[`TCC_CH_MSA];
	wire [1:0] els      = {ctl[`TCC_CH_ELSB], ctl[`TCC_CH_ELSA]};
	wire       active   = ~link_off_i & (els != 2'h0);
	wire       capture  = active & ~msb & ~msa; // RQ21
	wire       compare  = active & (msb | msa); // RQ20
	wire       rise     = s2 & ~s3;
	wire       fall     = ~s2 & s3;
	wire       edge_hit = capture & ((els[0] & rise) | (els[1] & fall));
	wire       match    = compare & step_i & ~inh & (count_i == val);
	wire       set_evt  = edge_hit | match; // RQ15
	wire       clr_ok   = sc_wr_i & ~wdata_i[`TCC_CH_FLAG] & armed;

	assign sc_o    = {flag, ctl[6], msb, ctl[4:0]}; // RQ19
	assign value_o = val;

	// Pin synchroniser; only s2 and s3 feed edge logic
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Flag with two-step clear; a new event beats the clear
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flag  <= 1'b0; // RQ18
			armed <= 1'b0;
		end else begin
			if (set_evt)
				flag <= 1'b1; // RQ15
			else if (clr_ok)
				flag <= 1'b0; // RQ16
			if (set_evt)
				armed <= 1'b0; // RQ16
			else if (sc_rd_i & flag)
				armed <= 1'b1; // RQ16
			else if (sc_wr_i)
				armed <= 1'b0;
		end
	end

	// Control bits and channel value
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl <= `TCC_CH_RST; // RQ18
			val <= 16'h0000;
			inh <= 1'b0;
		end else begin
			if (sc_wr_i)
				ctl <= wdata_i[6:0];
			if (edge_hit)
				val <= count_i;
			else if (hi_wr_i)
				val[15:8] <= wdata_i;
			else if (lo_wr_i)
				val[7:0] <= wdata_i;
			// Compare held off between high and low byte writes
			if (hi_wr_i)
				inh <= 1'b1;
			else if (lo_wr_i)
				inh <= 1'b0;
		end
	end

	// Pin action; overflow toggle has precedence over compare
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_o      <= 1'b1;
			pin_oe_n_o <= 1'b1;
			irq_o      <= 1'b0;
		end else begin
			pin_oe_n_o <= ~compare;
			irq_o      <= flag & ctl[`TCC_CH_IE]; // RQ17
			if (!compare)
				pin_o <= ~msa;
			else if (ctl[`TCC_CH_TOV] & wrap_i)
				pin_o <= ~pin_o; // RQ22
			else if (ctl[`TCC_CH_MAX] & ~ctl[`TCC_CH_TOV])
				pin_o <= ~els[0];
			else if (match) begin
				case (els)
				`TCC_EDGE_TOG: pin_o <= ~pin_o; // RQ21
				`TCC_EDGE_CLR: pin_o <= 1'b0;
				`TCC_EDGE_SET: pin_o <= 1'b1;
				default:       pin_o <= pin_o;
				endcase
			end
		end
	end

endmodule

// ### tb/tcc_timer_sva.sv
// Port-level assertions for the timer counter control core
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_timer_chk (
	// Clock and reset
	input wire        sys_clk_i,
	input wire        arst_n_i,
	// Bus signals
	input wire        hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0]  htrans_i,
	input wire        hwrite_i,
	input wire [31:0] hwdata_i,
	input wire        hready_i,
	input wire [31:0] hrdata_o,
	// Pins and requests
	input wire        shared_clock_pin_oe_n_o,
	input wire [5:0]  channel_pin_oe_n_o,
	input wire        overflow_irq_o,
	input wire [5:0]  channel_irq_o
);
	wire [47:0] ch_sc = `TCC_CH_SC_IDX;
	wire        take  = hsel_i & hready_i & htrans_i[1];
	reg         rd_v;
	reg         wr_v;
	reg  [7:0]  idx;
	reg         unt;
	reg         zh;
	reg         sel_ext;
	wire        rd_main = rd_v && idx == `TCC_IDX_MAIN;
	wire        rd_cnt  = rd_v && (idx == `TCC_IDX_CNT_HI ||
		idx == `TCC_IDX_CNT_LO);
	wire        rd_lim  = rd_v && (idx == 8'h23 || idx == 8'h24);
	wire        rd_odd  = rd_v && (idx == ch_sc[15:8] ||
		idx == ch_sc[31:24] || idx == ch_sc[47:40]);
	wire        rd_ch   = rd_odd || (rd_v && (idx == ch_sc[7:0] ||
		idx == ch_sc[23:16] || idx == ch_sc[39:32]));

	// ****************
	// Bus phase tracking
	// ****************
	// Zero-hold: counter known at zero while halted since a reset
	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_v <= 1'h0;
			wr_v <= 1'h0;
			idx <= 8'h00;
			unt <= 1'h1;
			zh <= 1'h1;
			sel_ext <= 1'h0;
		end else begin
			rd_v <= take & ~hwrite_i;
			wr_v <= take & hwrite_i;
			if (take)
				idx <= haddr_i[9:2];
			if (wr_v)
				unt <= 1'h0;
			if (wr_v && idx == `TCC_IDX_MAIN) begin
				zh <= hwdata_i[5] & (hwdata_i[4] | zh);
				sel_ext <= hwdata_i[2:0] == `TCC_PS_EXT;
			end
		end
	end

	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_main_reset: assert property (rd_main && unt |-> hrdata_o == 32'h20)
		else $error("main register not at reset value");
	a_limit_reset: assert property (rd_lim && unt |-> hrdata_o == 32'hFF)
		else $error("limit byte not all ones after reset");
	a_chan_reset: assert property (rd_ch && unt |-> hrdata_o == 32'h0)
		else $error("channel register not clear after reset");
	a_count_zero: assert property (rd_cnt && zh && $past(zh) |->
		hrdata_o[7:0] == 8'h00) else $error("halted count not zero");
	a_trst_reads0: assert property (rd_main |-> !hrdata_o[4])
		else $error("counter reset bit read back as one");
	a_odd_nobuf: assert property (rd_odd |-> !hrdata_o[5])
		else $error("odd channel shows buffered bit");
	a_clk_pin_in: assert property (sel_ext |=> shared_clock_pin_oe_n_o)
		else $error("clock pin driven while it is the timer clock");
	a_ovf_irq: assert property (rd_main && hrdata_o[7] && hrdata_o[6]
		|-> ##[0:1] overflow_irq_o) else $error("overflow request missing");
	a_reset_quiet: assert property ($rose(arst_n_i) |->
		channel_pin_oe_n_o == 6'h3F && channel_irq_o == 6'h00 &&
		!overflow_irq_o) else $error("outputs active after reset");

	// Main scenarios reached
	c_flag_seen: cover property (rd_main && hrdata_o[7]);
	c_ovf_irq: cover property ($rose(overflow_irq_o));
	c_chan_irq: cover property (channel_irq_o != 6'h00);
endmodule

bind tcc_timer tcc_timer_chk CHK (
	.sys_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
	.hwdata_i, .hready_i, .hrdata_o, .shared_clock_pin_oe_n_o,
	.channel_pin_oe_n_o, .overflow_irq_o, .channel_irq_o
);

// ### tb/tcc_far_side.sv
// Far-side model: external timer clock source and channel pin levels
`timescale 1ns/1ps

module tcc_far_side #(
	parameter HALF_NS = 125
) (
	// Controls from the bench
	input  wire        run_i,
	input  wire [5:0]  lvl_i,
	// Device channel pin drive
	input  wire [5:0]  drv_i,
	input  wire [5:0]  oe_n_i,
	// Levels seen by the device
	output logic       ext_clk_o,
	output logic [5:0] pin_o
);
	// 4 MHz source, far below half the bus rate; stands low when idle
	initial begin
		ext_clk_o = 1'h0;
		forever begin
			#(HALF_NS);
			ext_clk_o = run_i & ~ext_clk_o;
		end
	end

	// A driven pin reads back its own level, else the bench level
	assign pin_o = (oe_n_i & lvl_i) | (~oe_n_i & drv_i);
endmodule

// ### tb/test_tcc_timer.sv
// Self-checking bench of the timer core with a far-side pin model
`timescale 1ns/1ps
`include "tcc_consts.vh"

module test_tcc_timer;
	logic        sys_clk_i = 1'h0;
	logic        arst_n_i = 1'h0;
	logic        hsel_i = 1'h0;
	logic        hwrite_i = 1'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [1:0]  htrans_i = 2'h0;
	logic [2:0]  hsize_i = 3'h2;
	logic        pin_direction_bit_i = 1'h0;
	logic        shared_clock_pin_i;
	logic [5:0]  channel_pin_i;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        hresp_o;
	logic        shared_clock_pin_oe_n_o;
	logic        overflow_irq_o;
	logic [5:0]  channel_pin_o;
	logic [5:0]  channel_pin_oe_n_o;
	logic [5:0]  channel_irq_o;
	wire         hready_i = hreadyout_o;
	logic        ext_run = 1'h0;
	logic        hold = 1'h0;
	logic        mon_v = 1'h0;
	logic [5:0]  lvl = 6'h02;
	logic [7:0]  rdat;
	logic [15:0] v;
	logic [15:0] e;
	logic [15:0] q[$];
	wire  [47:0] ch_sc = `TCC_CH_SC_IDX;
	logic [7:0]  cap[3] = '{8'h44, 8'h48, 8'h4C};
	int          num_errors = 0;
	int          compares = 0;
	int          seed = 32'h38df98f4;
	int          i;

	// Bus clock, 200 MHz
	initial forever #2.5 sys_clk_i = ~sys_clk_i;

	tcc_timer DUT (
		.sys_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
		.hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o,
		.hresp_o, .shared_clock_pin_i, .pin_direction_bit_i,
		.shared_clock_pin_oe_n_o, .channel_pin_i, .channel_pin_o,
		.channel_pin_oe_n_o, .overflow_irq_o, .channel_irq_o
	);
	tcc_far_side FAR (.run_i(ext_run), .lvl_i(lvl), .drv_i(channel_pin_o),
		.oe_n_i(channel_pin_oe_n_o), .ext_clk_o(shared_clock_pin_i),
		.pin_o(channel_pin_i));

	// ****************
	// Checking
	// ****************
	task automatic check(input string n, input logic [31:0] s, x);
		compares++;
		if (s !== x) begin
			num_errors++;
			$display("ERROR %s expected %0h seen %0h", n, x, s);
		end
	endtask

	task automatic test_done();
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Read data phase watcher; a note holds mask and expected byte
	always @(posedge sys_clk_i) begin
		if (mon_v) begin
			e = q.pop_front();
			check("hrdata", hrdata_o & {24'hFF_FFFF, e[15:8]},
				{24'h0, e[7:0] & e[15:8]});
		end
		mon_v <= hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
	end

	// Port direction wanders unless held as output
	always @(posedge sys_clk_i)
		pin_direction_bit_i <= hold | 1'($random(seed));

	// ****************
	// Bus tasks
	// ****************
	task automatic bus(input logic w, input logic [7:0] a, d);
		hsel_i <= 1'h1;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		haddr_i <= {22'h0, a, 2'h0};
		@(posedge sys_clk_i);
		while (!hready_i) @(posedge sys_clk_i);
		htrans_i <= 2'h0;
		hwdata_i <= {24'h0, d};
		@(posedge sys_clk_i);
		while (!hready_i) @(posedge sys_clk_i);
		rdat = hrdata_o[7:0];
	endtask

	task automatic wr(input logic [7:0] a, d);
		bus(1'h1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, x, m);
		q.push_back({m, x});
		bus(1'h0, a, 8'h00);
	endtask

	task automatic rdcnt(output logic [15:0] c);
		rd(`TCC_IDX_CNT_HI, 8'h00, 8'h00);
		c[15:8] = rdat;
		rd(`TCC_IDX_CNT_LO, 8'h00, 8'h00);
		c[7:0] = rdat;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// Hang guard, far beyond the expected run
	initial begin
		#100000;
		num_errors++;
		test_done();
	end

	initial begin
		cyc(20);
		arst_n_i <= 1'h1;
		cyc(1);
		rd(`TCC_IDX_MAIN, 8'h20, 8'hFF);
		rd(`TCC_IDX_CNT_HI, 8'h00, 8'hFF);
		rd(`TCC_IDX_CNT_LO, 8'h00, 8'hFF);
		rd(`TCC_IDX_MOD_HI, 8'hFF, 8'hFF);
		rd(`TCC_IDX_MOD_LO, 8'hFF, 8'hFF);
		rd(8'h3F, 8'h00, 8'hFF);
		for (i = 0; i < 6; i++) rd(ch_sc[8*i+:8], 8'h00, 8'hFF);
		// Flag write of one ignored, odd channels lack buffered bit
		for (i = 0; i < 6; i++) begin
			wr(ch_sc[8*i+:8], 8'hE3);
			rd(ch_sc[8*i+:8], i[0] ? 8'h43 : 8'h63, 8'hFF);
			wr(ch_sc[8*i+:8], 8'h00);
		end
		wr(`TCC_IDX_CNT_LO, 8'h55);
		wr(`TCC_IDX_MAIN, 8'h30);
		rd(`TCC_IDX_MAIN, 8'h20, 8'hFF);
		rd(`TCC_IDX_CNT_LO, 8'h00, 8'hFF);
		// Bus clock prescaler codes 000 to 110 over a fixed span
		for (i = 0; i < 7; i++) begin
			wr(`TCC_IDX_MAIN, 8'h30);
			wr(`TCC_IDX_MAIN, i[7:0]);
			cyc(256);
			wr(`TCC_IDX_MAIN, 8'h20);
			rdcnt(v);
			check("count", v >= (256 >> i) && v <= (259 >> i) + 1, 1);
		end
		// External clock select with the port asking for output
		hold = 1'h1;
		wr(`TCC_IDX_MAIN, 8'h30);
		wr(`TCC_IDX_MAIN, 8'h07);
		ext_run <= 1'h1;
		cyc(400);
		ext_run <= 1'h0;
		cyc(10);
		check("clk pin oe_n", shared_clock_pin_oe_n_o, 1);
		wr(`TCC_IDX_MAIN, 8'h27);
		rdcnt(v);
		check("ext count", v >= 7 && v <= 9, 1);
		// Overflow flag: set, refused clear, armed clear
		wr(`TCC_IDX_MAIN, 8'h30);
		wr(`TCC_IDX_MOD_HI, 8'h00);
		wr(`TCC_IDX_MOD_LO, 8'h03);
		check("clk pin oe_n", shared_clock_pin_oe_n_o, 0);
		wr(`TCC_IDX_MAIN, 8'h40);
		cyc(20);
		wr(`TCC_IDX_MAIN, 8'hE0);
		wr(`TCC_IDX_MAIN, 8'h60);
		rd(`TCC_IDX_MAIN, 8'hE0, 8'hFF);
		#1 check("ovf irq", overflow_irq_o, 1);
		wr(`TCC_IDX_MAIN, 8'h60);
		rd(`TCC_IDX_MAIN, 8'h60, 8'hFF);
		#1 check("ovf irq", overflow_irq_o, 0);
		// A new overflow between the steps defeats the clear
		wr(`TCC_IDX_MAIN, 8'h00);
		cyc(20);
		rd(`TCC_IDX_MAIN, 8'h80, 8'hFF);
		cyc(8);
		wr(`TCC_IDX_MAIN, 8'h20);
		rd(`TCC_IDX_MAIN, 8'hA0, 8'hFF);
		wr(`TCC_IDX_MAIN, 8'h30);
		// Limit high write holds off the flag until the low write
		wr(`TCC_IDX_MOD_HI, 8'h00);
		wr(`TCC_IDX_MAIN, 8'h00);
		cyc(40);
		wr(`TCC_IDX_MAIN, 8'h20);
		rd(`TCC_IDX_MAIN, 8'h20, 8'hFF);
		wr(`TCC_IDX_MOD_LO, 8'h03);
		wr(`TCC_IDX_MAIN, 8'h00);
		cyc(20);
		wr(`TCC_IDX_MAIN, 8'h20);
		rd(`TCC_IDX_MAIN, 8'hA0, 8'hFF);
		wr(`TCC_IDX_MAIN, 8'h30);
		// Low byte latch survives counting and repeated high reads
		wr(`TCC_IDX_MOD_HI, 8'hFF);
		wr(`TCC_IDX_MOD_LO, 8'hFF);
		rd(`TCC_IDX_CNT_HI, 8'h00, 8'hFF);
		wr(`TCC_IDX_MAIN, 8'h00);
		cyc(100);
		wr(`TCC_IDX_MAIN, 8'h20);
		rd(`TCC_IDX_CNT_HI, 8'h00, 8'hFF);
		rd(`TCC_IDX_CNT_LO, 8'h00, 8'hFF);
		rdcnt(v);
		check("live count", v > 16'h0050 && v < 16'h0100, 1);
		// Captures on rising, falling and either edge
		wr(`TCC_IDX_MAIN, 8'h00);
		for (i = 0; i < 3; i++) wr(ch_sc[8*i+:8], cap[i]);
		lvl <= 6'h05;
		cyc(10);
		#1 check("ch irq", channel_irq_o[2:0], 3'h7);
		for (i = 0; i < 3; i++) rd(ch_sc[8*i+:8], cap[i] | 8'h80, 8'hFF);
		for (i = 0; i < 3; i++) wr(ch_sc[8*i+:8], cap[i] & 8'h3F);
		for (i = 0; i < 3; i++) rd(ch_sc[8*i+:8], cap[i] & 8'h3F, 8'hFF);
		// Compare on channel 3 at count five
		wr(`TCC_IDX_MAIN, 8'h30);
		wr(ch_sc[31:24] + `TCC_VAL_HI_OFS, 8'h00);
		wr(ch_sc[31:24] + `TCC_VAL_LO_OFS, 8'h05);
		wr(ch_sc[31:24], 8'h14);
		wr(`TCC_IDX_MAIN, 8'h00);
		cyc(20);
		rd(ch_sc[31:24], 8'h94, 8'hFF);
		#1 check("ch3 oe_n", channel_pin_oe_n_o[3], 0);
		check("ch3 pin", channel_pin_o[3], 0);
		// Compare at wrap: overflow toggle beats clear, three toggles
		wr(`TCC_IDX_MAIN, 8'h30);
		wr(`TCC_IDX_MOD_HI, 8'h00);
		wr(`TCC_IDX_MOD_LO, 8'h03);
		wr(ch_sc[31:24] + `TCC_VAL_HI_OFS, 8'h00);
		wr(ch_sc[31:24] + `TCC_VAL_LO_OFS, 8'h00);
		wr(ch_sc[31:24], 8'h1A);
		wr(`TCC_IDX_MAIN, 8'h00);
		cyc(10);
		wr(`TCC_IDX_MAIN, 8'h20);
		cyc(2);
		check("ch3 tov", channel_pin_o[3], 1);
		check("hresp", hresp_o, 0);
		cyc(4);
		check("notes left", q.size(), 0);
		test_done();
	end
endmodule
